//--- core/bsspd_consts.vh
// Purpose: Shared constants for the boot section self-program decode block
// Assumes: Included by bare name from core design files
// Notes: Offsets are byte addresses on a 32-bit classic Wishbone bus
`ifndef BSSPD_CONSTS_VH
`define BSSPD_CONSTS_VH

// Register byte offsets
`define BSSPD_OFS_CTRL 8'h00
`define BSSPD_OFS_EXTPG 8'h04
`define BSSPD_OFS_PTR 8'h08
`define BSSPD_OFS_CFG 8'h0C
`define BSSPD_OFS_STAT 8'h10

// Control and status field positions
`define BSSPD_CS_IRQ_EN 7
`define BSSPD_CS_BUSY 6
`define BSSPD_CS_STORE_PROGRAM_ENABLE 0

// Accepted codes of the lower five control bits
`define BSSPD_CODE_LOAD 5'h01
`define BSSPD_CODE_ERASE 5'h03
`define BSSPD_CODE_WRITE 5'h05
`define BSSPD_CODE_LOCK 5'h09
`define BSSPD_CODE_REEN 5'h11

// Reset values
`define BSSPD_RST_CODE 5'h00
`define BSSPD_RST_BYTE 8'h00
`define BSSPD_RST_PTR 16'h0000

// Arm window: cycles in which a store instruction is taken
`define BSSPD_ARM_CYCLES 3'h4
`define BSSPD_ARM_LAST 3'h3

// Boot start, 128K-byte variant (bit 16 always zero)
`define BSSPD_BOOT_S11 17'h0FE00
`define BSSPD_BOOT_S10 17'h0FC00
`define BSSPD_BOOT_S01 17'h0F800
`define BSSPD_BOOT_S00 17'h0F000
// Boot start, 17-bit variant
`define BSSPD_BOOT_L11 17'h1FE00
`define BSSPD_BOOT_L10 17'h1FC00
`define BSSPD_BOOT_L01 17'h1F800
`define BSSPD_BOOT_L00 17'h1F000

// First address of the non-concurrent section
`define BSSPD_NRW_START_S 17'h0F000
`define BSSPD_NRW_START_L 17'h1F000

// Pointer mapping: word bits, page bits
`define BSSPD_WORD_TOP 6
`define BSSPD_PAGE_LSB 7

`endif

//--- core/bsspd_section_decode.v
// Purpose: Classify a program word address against boot and section limits
// Assumes: boot_size is the captured fuse code, {hi, lo}
// Notes: Pure combinational; bit 16 is masked off on the 128K-byte variant
`timescale 1ns/1ps
`default_nettype none
`include "bsspd_consts.vh"

module bsspd_section_decode (
  input wire large_variant,
  input wire [1:0] boot_size,
  input wire [16:0] addr,
  output reg [16:0] boot_start,
  output wire in_boot,
  output wire in_nonconc
);

  wire [16:0] addr_m;
  wire [16:0] nrw_start;

  // Small variant has a 16-bit address, so its top bit never counts
  assign addr_m = large_variant ? addr : {1'b0, addr[15:0]};

  // Boot start selected by fuse code and variant
  always @* begin
    case (boot_size)
      2'b11: boot_start = large_variant ? `BSSPD_BOOT_L11 : `BSSPD_BOOT_S11;
      2'b10: boot_start = large_variant ? `BSSPD_BOOT_L10 : `BSSPD_BOOT_S10;
      2'b01: boot_start = large_variant ? `BSSPD_BOOT_L01 : `BSSPD_BOOT_S01;
      default: boot_start = large_variant ? `BSSPD_BOOT_L00 : `BSSPD_BOOT_S00;
    endcase
  end

  // Boot section runs from its start to the top of flash
  assign in_boot = (addr_m >= boot_start);

  // Fixed split between concurrent and non-concurrent sections
  assign nrw_start = large_variant ? `BSSPD_NRW_START_L : `BSSPD_NRW_START_S;
  assign in_nonconc = (addr_m >= nrw_start);

endmodule // bsspd_section_decode
`default_nettype wire

//--- core/bsspd_top.v
// Purpose: Self-program decode and control front end with Wishbone registers
// Assumes: CPU strobes are one-cycle pulses synchronous to mclk
// Notes: Erase/write timing lives in an external sequencer (flash_op_done)
//
// Summary of operation
// - 128K boot start from two fuse bits
// - 17-bit boot start from two fuse bits
// - 128K concurrent/non-concurrent split at 0xF000
// - 17-bit concurrent/non-concurrent split at 0x1F000
// - 128K word address from pointer bits 16..1
// - 17-bit word address from pointer bits 17..1
// - Word-in-page from pointer bits 7..1
// - Page select from pointer bit 8 upward
// - Pointer bit 0 is load byte select
// - Address bit 16 from extended page register
// - Ready interrupt needs enable and global flag
// - Ready interrupt is level while enable clear
// - One control and status register
// - Enable bit arms four cycles, self-clears
// - Only five lower-bit codes are accepted
// - Concurrent erase/write sets busy, blocks section
// - Re-enable during page load aborts load
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "bsspd_consts.vh"

module bsspd_top (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire boot_size_sel_hi,
  input wire boot_size_sel_lo,
  input wire global_irq_flag,
  input wire store_program_instr,
  input wire program_load_instr,
  input wire flash_op_done,
  input wire [16:0] fetch_addr,
  output wire [16:0] prog_word_addr,
  output wire [9:0] page_select_field,
  output wire [6:0] word_select_field,
  output wire load_byte_select,
  output wire cmd_page_load,
  output wire cmd_page_erase,
  output wire cmd_page_write,
  output wire cmd_lock_set,
  output wire cmd_reenable,
  output wire load_abort,
  output wire concurrent_section_busy,
  output wire fetch_blocked,
  output wire fetch_in_boot,
  output wire store_ready_irq
);

  // One-hot sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_BUSY = 3'b100;

  reg [2:0] st_q;
  reg [2:0] arm_cnt_q;
  reg [4:0] code_q;
  reg irq_en_q;
  reg busy_q;
  reg buf_loading_q;
  reg [7:0] ext_page_q;
  reg [15:0] ptr_q;
  reg large_q;
  reg [1:0] boot_size_q;
  reg fuse_taken_q;
  reg ack_q;
  reg [31:0] rdata_q;
  reg byte_sel_q;
  reg load_p_q;
  reg erase_p_q;
  reg write_p_q;
  reg lock_p_q;
  reg reen_p_q;
  reg abort_p_q;

  wire wb_req;
  wire wb_wr;
  wire ctrl_wr;
  wire code_ok;
  wire [23:0] ptr_full;
  wire [16:0] word_addr;
  wire [16:0] boot_start;
  wire ptr_in_boot;
  wire ptr_nonconc;
  wire fetch_nonconc;
  wire store_program_enable;
  wire [7:0] ctrl_rd;

  // Full pointer: extended page register supplies bits above 15
  assign ptr_full = {ext_page_q, ptr_q};

  // Bit 0 is dropped; variant picks how many upper bits are mapped
  assign word_addr = large_q ? ptr_full[17:1]
                             : {1'b0, ptr_full[16:1]};

  assign prog_word_addr = word_addr;
  // Page select starts at word bit 7, i.e. pointer bit 8
  assign page_select_field = word_addr[16:`BSSPD_PAGE_LSB];
  // Word within a 128-word page
  assign word_select_field = word_addr[`BSSPD_WORD_TOP:0];
  // The CPU keeps word select zero for a page write; nothing here forces it
  // so a nonzero value is passed through unchanged

  // Pointer address classification
  bsspd_section_decode u_ptr_dec (
    .large_variant(large_q),
    .boot_size(boot_size_q),
    .addr(word_addr),
    .boot_start(boot_start),
    .in_boot(ptr_in_boot),
    .in_nonconc(ptr_nonconc)
  );

  // Core fetch address classification
  bsspd_section_decode u_fetch_dec (
    .large_variant(large_q),
    .boot_size(boot_size_q),
    .addr(fetch_addr),
    .boot_start(),
    .in_boot(fetch_in_boot),
    .in_nonconc(fetch_nonconc)
  );

  // Busy section refuses access from the core
  assign fetch_blocked = busy_q & ~fetch_nonconc;
  assign concurrent_section_busy = busy_q;

  assign store_program_enable = code_q[`BSSPD_CS_STORE_PROGRAM_ENABLE];

  // Level request while enabled and no store is pending
  assign store_ready_irq = irq_en_q & global_irq_flag & ~store_program_enable;

  // Wishbone classic: one request per ack, ack one cycle after strobe
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr = wb_req & wb_we_i;
  assign ctrl_wr = wb_wr & wb_sel_i[0] & (wb_adr_i == `BSSPD_OFS_CTRL);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Only the five documented codes arm the sequencer
  assign code_ok = (wb_dat_i[4:0] == `BSSPD_CODE_LOAD) |
                   (wb_dat_i[4:0] == `BSSPD_CODE_ERASE) |
                   (wb_dat_i[4:0] == `BSSPD_CODE_WRITE) |
                   (wb_dat_i[4:0] == `BSSPD_CODE_LOCK) |
                   (wb_dat_i[4:0] == `BSSPD_CODE_REEN);

  // Single control and status byte; bit 5 reads zero
  assign ctrl_rd = {irq_en_q, busy_q, 1'b0, code_q};

  assign load_byte_select = byte_sel_q;
  assign cmd_page_load = load_p_q;
  assign cmd_page_erase = erase_p_q;
  assign cmd_page_write = write_p_q;
  assign cmd_lock_set = lock_p_q;
  assign cmd_reenable = reen_p_q;
  assign load_abort = abort_p_q;

  // Fuses are static: take them once on the first enabled edge after reset
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      boot_size_q <= 2'h0;
      fuse_taken_q <= 1'b0;
    end else if (ce && !fuse_taken_q) begin
      boot_size_q <= {boot_size_sel_hi, boot_size_sel_lo};
      fuse_taken_q <= 1'b1;
    end
  end

  // Bus slave: ack, read mux, and plain data registers
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ext_page_q <= `BSSPD_RST_BYTE;
      ptr_q <= `BSSPD_RST_PTR;
      large_q <= 1'b0;
    end else if (ce) begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `BSSPD_OFS_CTRL: rdata_q <= {24'h000000, ctrl_rd};
          `BSSPD_OFS_EXTPG: rdata_q <= {24'h000000, ext_page_q};
          `BSSPD_OFS_PTR: rdata_q <= {16'h0000, ptr_q};
          `BSSPD_OFS_CFG: rdata_q <= {31'h00000000, large_q};
          `BSSPD_OFS_STAT: rdata_q <= {7'h00, boot_start, 3'h0, fuse_taken_q,
                                       boot_size_q, ptr_nonconc, ptr_in_boot};
          default: rdata_q <= 32'h00000000;
        endcase
      end
      if (wb_wr) begin
        case (wb_adr_i)
          `BSSPD_OFS_EXTPG: begin
            if (wb_sel_i[0]) begin
              ext_page_q <= wb_dat_i[7:0];
            end
          end
          `BSSPD_OFS_PTR: begin
            if (wb_sel_i[0]) begin
              ptr_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              ptr_q[15:8] <= wb_dat_i[15:8];
            end
          end
          `BSSPD_OFS_CFG: begin
            if (wb_sel_i[0]) begin
              large_q <= wb_dat_i[0];
            end
          end
          default: begin
            ack_q <= wb_req;
          end
        endcase
      end
    end
  end

  // Byte select is captured when a program load instruction executes
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      byte_sel_q <= 1'b0;
    end else if (ce && program_load_instr) begin
      byte_sel_q <= ptr_q[0];
    end
  end

  // Interrupt enable is writable at any time, independent of the code
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_en_q <= 1'b0;
    end else if (ce && ctrl_wr) begin
      irq_en_q <= wb_dat_i[`BSSPD_CS_IRQ_EN];
    end
  end

  // Store sequencer: arm window, command issue, busy hold.
  // Codes are refused outside idle so only one store is ever active.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      arm_cnt_q <= 3'h0;
      code_q <= `BSSPD_RST_CODE;
      busy_q <= 1'b0;
      buf_loading_q <= 1'b0;
      load_p_q <= 1'b0;
      erase_p_q <= 1'b0;
      write_p_q <= 1'b0;
      lock_p_q <= 1'b0;
      reen_p_q <= 1'b0;
      abort_p_q <= 1'b0;
    end else if (ce) begin
      load_p_q <= 1'b0;
      erase_p_q <= 1'b0;
      write_p_q <= 1'b0;
      lock_p_q <= 1'b0;
      reen_p_q <= 1'b0;
      abort_p_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (ctrl_wr && code_ok) begin
            code_q <= wb_dat_i[4:0];
            arm_cnt_q <= 3'h0;
            st_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (store_program_instr) begin
            arm_cnt_q <= 3'h0;
            case (code_q)
              `BSSPD_CODE_ERASE: begin
                erase_p_q <= 1'b1;
                busy_q <= busy_q | ~ptr_nonconc;
                st_q <= ST_BUSY;
              end
              `BSSPD_CODE_WRITE: begin
                write_p_q <= 1'b1;
                busy_q <= busy_q | ~ptr_nonconc;
                buf_loading_q <= 1'b0;
                st_q <= ST_BUSY;
              end
              `BSSPD_CODE_LOCK: begin
                lock_p_q <= 1'b1;
                code_q <= `BSSPD_RST_CODE;
                st_q <= ST_IDLE;
              end
              `BSSPD_CODE_REEN: begin
                reen_p_q <= 1'b1;
                busy_q <= 1'b0;
                // Buffered words are discarded, not written
                abort_p_q <= buf_loading_q;
                buf_loading_q <= 1'b0;
                code_q <= `BSSPD_RST_CODE;
                st_q <= ST_IDLE;
              end
              default: begin
                // Plain enable: one word into the page buffer
                load_p_q <= 1'b1;
                busy_q <= 1'b0;
                buf_loading_q <= 1'b1;
                code_q <= `BSSPD_RST_CODE;
                st_q <= ST_IDLE;
              end
            endcase
          end else if (arm_cnt_q == `BSSPD_ARM_LAST) begin
            // Window of four cycles expired with no store
            code_q <= `BSSPD_RST_CODE;
            arm_cnt_q <= 3'h0;
            st_q <= ST_IDLE;
          end else begin
            arm_cnt_q <= arm_cnt_q + 3'h1;
          end
        end
        ST_BUSY: begin
          // Enable stays high until the sequencer reports the end
          if (flash_op_done) begin
            code_q <= `BSSPD_RST_CODE;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          code_q <= `BSSPD_RST_CODE;
        end
      endcase
    end
  end

endmodule // bsspd_top
`default_nettype wire

//--- bench/bsspd_monitor.sv
// Purpose: Port-level checks for the self-program decode block
// Assumes: Bound to bsspd_top, one clock domain on mclk
// Notes: Internal enables are unseen, so outputs are tied to each other
`timescale 1ns/1ps
`default_nettype none
module bsspd_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic global_irq_flag,
  input wire logic store_program_instr,
  input wire logic [16:0] prog_word_addr,
  input wire logic [9:0] page_select_field,
  input wire logic [6:0] word_select_field,
  input wire logic cmd_page_load,
  input wire logic cmd_page_erase,
  input wire logic cmd_page_write,
  input wire logic cmd_lock_set,
  input wire logic cmd_reenable,
  input wire logic load_abort,
  input wire logic concurrent_section_busy,
  input wire logic fetch_blocked,
  input wire logic store_ready_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Any command pulse, gathered once
  wire logic [4:0] cmds;
  assign cmds = {cmd_reenable, cmd_lock_set, cmd_page_write, cmd_page_erase, cmd_page_load};
  // A command needs a store instruction on the edge before it
  sequence store_seen_s;
    $past(store_program_instr);
  endsequence
  sequence cmd_issued_s;
    (|cmds) ##0 store_seen_s;
  endsequence
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  cmd_cause_a: assert property ((|cmds) |-> cmd_issued_s)
    else $error("command pulse without store instruction");
  cmd_onehot_a: assert property ($onehot0(cmds) and ((|cmds) |=> !(|cmds)))
    else $error("command pulses overlap or stretch");
  busy_rise_a: assert property ($rose(concurrent_section_busy) |-> cmd_page_erase || cmd_page_write)
    else $error("busy set without erase or write");
  busy_fall_a: assert property ($fell(concurrent_section_busy) |-> cmd_reenable || cmd_page_load)
    else $error("busy cleared without reenable or load");
  fetch_block_a: assert property (fetch_blocked |-> concurrent_section_busy)
    else $error("fetch blocked while not busy");
  irq_gate_a: assert property (store_ready_irq |-> global_irq_flag)
    else $error("ready request without global flag");
  load_abort_a: assert property (load_abort |-> cmd_reenable)
    else $error("abort without reenable");
  field_split_a: assert property ({page_select_field, word_select_field} == prog_word_addr)
    else $error("page and word fields disagree with address");
  busy_cov: cover property ($rose(concurrent_section_busy));
endmodule // bsspd_monitor

bind bsspd_top bsspd_monitor mon_u (
  .mclk(mclk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .global_irq_flag(global_irq_flag),
  .store_program_instr(store_program_instr), .prog_word_addr(prog_word_addr),
  .page_select_field(page_select_field), .word_select_field(word_select_field),
  .cmd_page_load(cmd_page_load), .cmd_page_erase(cmd_page_erase),
  .cmd_page_write(cmd_page_write), .cmd_lock_set(cmd_lock_set),
  .cmd_reenable(cmd_reenable), .load_abort(load_abort),
  .concurrent_section_busy(concurrent_section_busy), .fetch_blocked(fetch_blocked),
  .store_ready_irq(store_ready_irq)
);
`default_nettype wire

//--- bench/bsspd_cpu_model.sv
// Purpose: CPU core and flash sequencer stand-in for the decode block
// Assumes: Pulses last one mclk cycle and start just after a rising edge
// Notes: OP_CYCLES sets how slowly an erase or write completes
`timescale 1ns/1ps
`default_nettype none
module bsspd_cpu_model #(
  parameter int OP_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_start,
  output logic store_instr,
  output logic load_instr,
  output logic op_done
);
  int left_q;
  initial begin
    store_instr = 1'b0;
    load_instr = 1'b0;
  end
  // Store after n edges; a late one probes the end of the arm window
  task automatic store_after(input int n);
    repeat (n) @(posedge mclk);
    store_instr <= 1'b1;
    @(posedge mclk);
    store_instr <= 1'b0;
  endtask
  // One load instruction
  task automatic load_once();
    load_instr <= 1'b1;
    @(posedge mclk);
    load_instr <= 1'b0;
  endtask
  // Flash finishes an erase or write some cycles later, never at once
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      left_q <= 0;
      op_done <= 1'b0;
    end else begin
      op_done <= (left_q == 1);
      if (op_start)
        left_q <= OP_CYCLES;
      else if (left_q > 0)
        left_q <= left_q - 1;
    end
  end
endmodule // bsspd_cpu_model
`default_nettype wire

//--- bench/test_bsspd_top.sv
// Purpose: Self-checking bench for the self-program decode block
// Assumes: Classic Wishbone master, ack one cycle after the taking edge
// Notes: Each fuse code needs its own reset since fuses are taken once
`timescale 1ns/1ps
`default_nettype none
`include "bsspd_consts.vh"
module test_bsspd_top;
  logic mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fz_hi = 1'b0, fz_lo = 1'b0, gie = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [16:0] fetch = 17'h0;
  wire logic [31:0] rdat;
  wire logic [16:0] pwa;
  wire logic [9:0] psf;
  wire logic [6:0] wsf;
  wire logic [4:0] cmds;
  wire logic ack, st, ld, done, lbs, busy, fblk, fib, irq, abt;
  int mismatches = 0, compares = 0, aborts = 0;
  int cnt [5] = '{default: 0};
  always #10 mclk = ~mclk;
  bsspd_cpu_model cpu_u (.mclk(mclk), .reset(reset), .op_start(cmds[1] | cmds[2]),
    .store_instr(st), .load_instr(ld), .op_done(done));
  bsspd_top dut_u (.mclk(mclk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .boot_size_sel_hi(fz_hi), .boot_size_sel_lo(fz_lo),
    .global_irq_flag(gie), .store_program_instr(st), .program_load_instr(ld),
    .flash_op_done(done), .fetch_addr(fetch), .prog_word_addr(pwa),
    .page_select_field(psf), .word_select_field(wsf), .load_byte_select(lbs),
    .cmd_page_load(cmds[0]), .cmd_page_erase(cmds[1]), .cmd_page_write(cmds[2]),
    .cmd_lock_set(cmds[3]), .cmd_reenable(cmds[4]), .load_abort(abt),
    .concurrent_section_busy(busy), .fetch_blocked(fblk), .fetch_in_boot(fib),
    .store_ready_irq(irq));
  // Tally command pulses so scenarios compare totals
  always @(posedge mclk) begin
    for (int i = 0; i < 5; i++) cnt[i] += cmds[i];
    aborts += abt;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle.
  // No local limit: a slave that never answers is left to the watchdog.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic fchk(input logic [16:0] a, input logic e_boot, input logic e_blk);
    @(posedge mclk);
    fetch <= a;
    @(negedge mclk);
    chk(fib, e_boot);
    chk(fblk, e_blk);
  endtask
  task automatic do_reset(input logic [1:0] c);
    fz_hi <= c[1];
    fz_lo <= c[0];
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Write a code, issue the store at the window's last edge, wait for idle
  task automatic op(input logic [4:0] code);
    wb(1'b1, `BSSPD_OFS_CTRL, {27'h0, code});
    cpu_u.store_after(1);
    for (int i = 0; i < 40; i++) begin
      wb(1'b0, `BSSPD_OFS_CTRL, 32'h0);
      if (q[0] === 1'b0) break;
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  initial begin
    logic [16:0] s;
    logic [4:0] codes [5];
    int idx [5];
    logic bexp [5];
    int b;
    codes = '{5'h03, 5'h11, 5'h05, 5'h09, 5'h01};
    idx = '{1, 4, 2, 3, 0};
    bexp = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      rd_chk(`BSSPD_OFS_CTRL, 32'hFF, 32'h0);
      s = 17'h10000 - (17'd512 << (3 - c));
      fz_hi <= ~fz_hi;
      rd_chk(`BSSPD_OFS_STAT, 32'h01FFFF1C, ({15'h0, s} << 8) | (c << 2) | 32'h10);
      wb(1'b1, `BSSPD_OFS_CFG, 32'h1);
      rd_chk(`BSSPD_OFS_STAT, 32'h01FFFF00, ({15'h0, s | 17'h10000} << 8));
      fchk(s | 17'h10000, 1'b1, 1'b0);
      fchk((s | 17'h10000) - 17'h1, 1'b0, 1'b0);
    end
    // Pointer mapping on both variants, pointer bit 0 as byte select
    wb(1'b1, `BSSPD_OFS_CFG, 32'h0);
    wb(1'b1, `BSSPD_OFS_EXTPG, 32'h3);
    wb(1'b1, `BSSPD_OFS_PTR, 32'hABCD);
    @(negedge mclk);
    chk(pwa, 17'h0D5E6);
    chk(wsf, 7'h66);
    chk(psf, 17'h0D5E6 >> 7);
    wb(1'b1, `BSSPD_OFS_CFG, 32'h1);
    @(negedge mclk);
    chk(psf, 17'h1D5E6 >> 7);
    @(posedge mclk);
    cpu_u.load_once();
    @(negedge mclk);
    chk(lbs, 1'b1);
    // Commands from the concurrent section, word select and bit 0 kept zero
    wb(1'b1, `BSSPD_OFS_CFG, 32'h0);
    wb(1'b1, `BSSPD_OFS_EXTPG, 32'h0);
    wb(1'b1, `BSSPD_OFS_PTR, 32'h0200);
    wb(1'b1, `BSSPD_OFS_CTRL, 32'h07);
    rd_chk(`BSSPD_OFS_CTRL, 32'hFF, 32'h0);
    for (int i = 0; i < 5; i++) begin
      b = cnt[idx[i]];
      op(codes[i]);
      chk(cnt[idx[i]] - b, 32'h1);
      rd_chk(`BSSPD_OFS_CTRL, 32'h41, {25'h0, bexp[i], 6'h0});
      if (i == 0) begin
        fchk(17'h0EFFF, 1'b0, 1'b1);
        fchk(17'h0F000, 1'b0, 1'b0);
      end
    end
    // Larger variant: both sides of the section limit
    wb(1'b1, `BSSPD_OFS_CFG, 32'h1);
    wb(1'b1, `BSSPD_OFS_EXTPG, 32'h3);
    wb(1'b1, `BSSPD_OFS_PTR, 32'hDFFE);
    op(5'h03);
    fchk(17'h1EFFF, 1'b0, 1'b1);
    fchk(17'h1F000, 1'b0, 1'b0);
    op(5'h11);
    chk(aborts, 32'h1);
    wb(1'b1, `BSSPD_OFS_PTR, 32'hE000);
    op(5'h03);
    rd_chk(`BSSPD_OFS_CTRL, 32'h40, 32'h0);
    rd_chk(`BSSPD_OFS_STAT, 32'h3, 32'h2);
    // A store one edge past the window is ignored
    b = cnt[0];
    wb(1'b1, `BSSPD_OFS_CTRL, 32'h01);
    cpu_u.store_after(2);
    repeat (2) @(posedge mclk);
    chk(cnt[0] - b, 32'h0);
    rd_chk(`BSSPD_OFS_CTRL, 32'hFF, 32'h0);
    // Ready request: enable, global flag, armed state
    @(posedge mclk);
    gie <= 1'b1;
    wb(1'b1, `BSSPD_OFS_CTRL, 32'h80);
    @(negedge mclk);
    chk(irq, 1'b1);
    @(posedge mclk);
    gie <= 1'b0;
    @(negedge mclk);
    chk(irq, 1'b0);
    @(posedge mclk);
    gie <= 1'b1;
    wb(1'b1, `BSSPD_OFS_CTRL, 32'h81);
    @(negedge mclk);
    chk(irq, 1'b0);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(irq, 1'b1);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    close_out();
  end
endmodule // test_bsspd_top
`default_nettype wire
